// file: compress_module_ctrl.sv
`timescale 1ns/100ps
module compress_module_ctrl (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // chroma path
  input  wire logic [7:0]  chroma_i,
  output logic      [7:0]  chroma_o,
  // line buffer overflow event
  input  wire logic        lb_overflow_i,
  // controls to the module group
  output logic             fast_huff_o,
  output logic             marker_fast_o,
  output logic             rotate_o,
  output logic             module_rst_o,
  output logic             module_clk_en_o,
  output logic             codec_clk_en_o,
  output logic             codec_access_o,
  output logic             encode_mode_o,
  output logic      [1:0]  capture_fmt_o,
  output logic             lb_overflow_flag_o
);

  logic [15:0] ctrl_r;
  logic        wr_hit;
  logic        rd_hit;
  logic        access;
  logic        enc_mode;
  logic        capture;
  logic        swrst;
  logic [1:0]  fmt_nxt;

  assign access   = psel_i && penable_i && pready_o;
  assign wr_hit   = access && pwrite_i && (paddr_i == compress_ctrl_pkg::CTRL_OFFSET);
  assign rd_hit   = access && !pwrite_i && (paddr_i == compress_ctrl_pkg::CTRL_OFFSET);
  assign enc_mode = ctrl_r[compress_ctrl_pkg::MODE_MSB:compress_ctrl_pkg::MODE_LSB] == compress_ctrl_pkg::MODE_ENCODE;
  // reserved mode codes are treated as neither encode nor capture
  assign capture  = (ctrl_r[compress_ctrl_pkg::MODE_MSB:compress_ctrl_pkg::MODE_LSB] == compress_ctrl_pkg::MODE_CAP422)
                 || (ctrl_r[compress_ctrl_pkg::MODE_MSB:compress_ctrl_pkg::MODE_LSB] == compress_ctrl_pkg::MODE_CAP420);
  // reset pulse only when enabled before this write
  assign swrst    = wr_hit && pwdata_i[compress_ctrl_pkg::SWRST_BIT] && ctrl_r[compress_ctrl_pkg::ENABLE_BIT];

  // one-cycle answer: pready low in first access cycle, high in second
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i && penable_i && !pready_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      pslverr_o <= 1'b0;
    else
      pslverr_o <= psel_i && penable_i && !pready_o && (paddr_i != compress_ctrl_pkg::CTRL_OFFSET);
  end

  // reserved bits and the write-only reset bit are not stored
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ctrl_r <= compress_ctrl_pkg::CTRL_RESET;
    else if (wr_hit)
      ctrl_r <= pwdata_i[15:0] & compress_ctrl_pkg::CTRL_WRITE_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i && (paddr_i == compress_ctrl_pkg::CTRL_OFFSET))
      prdata_o <= {16'h0000, ctrl_r};
    // unmapped reads return zero even when the previous transfer was back to back
    else if (psel_i && !penable_i)
      prdata_o <= 32'h0000_0000;
    else if (rd_hit)
      prdata_o <= prdata_o;
    else if (!psel_i)
      prdata_o <= 32'h0000_0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      module_rst_o <= 1'b0;
    else
      module_rst_o <= swrst;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      lb_overflow_flag_o <= 1'b0;
    else if (lb_overflow_i)
      lb_overflow_flag_o <= 1'b1;
    else if (swrst)
      lb_overflow_flag_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      fast_huff_o   <= 1'b0;
      marker_fast_o <= 1'b0;
      rotate_o      <= 1'b0;
    end
    else
    begin
      fast_huff_o   <= ctrl_r[compress_ctrl_pkg::FAST_ENC_BIT];
      marker_fast_o <= ctrl_r[compress_ctrl_pkg::FAST_ENC_BIT] && ctrl_r[compress_ctrl_pkg::MARKER_FAST_BIT];
      rotate_o      <= ctrl_r[compress_ctrl_pkg::ROTATE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      module_clk_en_o <= 1'b0;
      codec_clk_en_o  <= 1'b0;
      codec_access_o  <= 1'b0;
      encode_mode_o   <= 1'b0;
    end
    else
    begin
      module_clk_en_o <= ctrl_r[compress_ctrl_pkg::ENABLE_BIT];
      codec_clk_en_o  <= ctrl_r[compress_ctrl_pkg::ENABLE_BIT] && !capture;
      codec_access_o  <= ctrl_r[compress_ctrl_pkg::ENABLE_BIT] && !capture;
      encode_mode_o   <= ctrl_r[compress_ctrl_pkg::ENABLE_BIT] && enc_mode;
    end
  end

  always_comb
  begin
    fmt_nxt = compress_ctrl_pkg::FMT_NONE_E;
    if (ctrl_r[compress_ctrl_pkg::MODE_MSB:compress_ctrl_pkg::MODE_LSB] == compress_ctrl_pkg::MODE_CAP422)
      fmt_nxt = compress_ctrl_pkg::FMT_422_E;
    else if (ctrl_r[compress_ctrl_pkg::MODE_MSB:compress_ctrl_pkg::MODE_LSB] == compress_ctrl_pkg::MODE_CAP420)
      fmt_nxt = compress_ctrl_pkg::FMT_420_E;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      capture_fmt_o <= compress_ctrl_pkg::FMT_NONE_E;
    else
      capture_fmt_o <= fmt_nxt;
  end

  // flipping the msb maps offset-binary to two's complement and back
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      chroma_o <= 8'h00;
    else if (ctrl_r[compress_ctrl_pkg::UV_PASS_BIT])
      chroma_o <= chroma_i;
    else
      chroma_o <= chroma_i ^ compress_ctrl_pkg::CHROMA_OFFSET;
  end

endmodule : compress_module_ctrl

// file: compress_ctrl_pkg.sv
// How it works
// - encode fast mode bit selects the fixed huffman table for compression
// - marker fast output bit makes markers come out using the fixed table
// - marker fast output only acts while encode fast mode is also set
// - rotation enable bit rotates encoded image data 180 degrees line by line
// - writing 1 to reset bit resets modules except codec, registers kept
// - software reset acts only while module enable is 1
// - uv conversion bit 0 translates chroma offset ranges, 1 passes unchanged
// - mode field: 000 encode, 011 yuv422 capture, 111 yuv420 capture
// - capture modes stop codec clock and block codec register access
// - encode mode accepts 444, 422, 411, 420; 444 only below half size
// - capture format from mode field, encode format from codec format field
// - module enable 0 stops module clock and blocks codec access
// - module software reset also clears line buffer overflow flag; an overflow in the same cycle wins and sets it
package compress_ctrl_pkg;
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hC11F;
  localparam int          FAST_ENC_BIT    = 15;
  localparam int          MARKER_FAST_BIT = 14;
  localparam int          ROTATE_BIT      = 8;
  localparam int          SWRST_BIT       = 7;
  localparam int          UV_PASS_BIT     = 4;
  localparam int          MODE_LSB        = 1;
  localparam int          MODE_MSB        = 3;
  localparam int          ENABLE_BIT      = 0;
  localparam logic [2:0]  MODE_ENCODE     = 3'h0;
  localparam logic [2:0]  MODE_CAP422     = 3'h3;
  localparam logic [2:0]  MODE_CAP420     = 3'h7;
  localparam logic [7:0]  CHROMA_OFFSET   = 8'h80;
  typedef enum logic [1:0] {
    FMT_NONE_E,
    FMT_422_E,
    FMT_420_E
  } cap_fmt_type;
endpackage : compress_ctrl_pkg

// file: ctrl_monitor.sv
`timescale 1ns/100ps
module ctrl_monitor (
  input wire logic       clk_i, rstn_i, pready_o, pslverr_o, module_rst_o, module_clk_en_o,
  input wire logic       fast_huff_o, marker_fast_o, codec_clk_en_o, codec_access_o, encode_mode_o,
  input wire logic [1:0] capture_fmt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  rdy_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error alone");
  marker_gate_a: assert property (marker_fast_o |-> fast_huff_o) else $error("marker alone");
  rst_pulse_a: assert property (module_rst_o |=> !module_rst_o) else $error("reset held");
  rst_enable_a: assert property (module_rst_o |-> $past(module_clk_en_o)) else $error("reset when off");
  capture_stop_a: assert property (capture_fmt_o != 2'h0 |-> !codec_clk_en_o) else $error("clock on");
  off_block_a: assert property (!module_clk_en_o |-> !codec_access_o && !encode_mode_o) else $error("off");
  encode_sel_a: assert property (encode_mode_o |-> capture_fmt_o == 2'h0 && codec_access_o) else $error("mode");
endmodule : ctrl_monitor
bind compress_module_ctrl ctrl_monitor mon (.*);

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, lb_overflow_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [7:0] chroma_i = 8'hF0, chroma_o;
  logic [1:0] capture_fmt_o;
  logic pready_o, pslverr_o, fast_huff_o, marker_fast_o, rotate_o, module_rst_o, module_clk_en_o;
  logic codec_clk_en_o, codec_access_o, encode_mode_o, lb_overflow_flag_o, er;
  int err_total = 0, n_tests = 0;
  compress_module_ctrl uut (.*);
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: %h %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask : apb
  // derived outputs settle one edge after the write
  task automatic wr(input logic [15:0] d);
    apb(1'b1, 12'h000, {16'h0, d});
    repeat (3) @(posedge clk_i);
  endtask : wr
  task automatic fast_modes;
    wr(16'hC19F);
    chk({fast_huff_o, marker_fast_o, rotate_o}, 3'h7);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000C11F);
    wr(16'h4000);
    chk({fast_huff_o, marker_fast_o, rotate_o}, 3'h0);
    wr(16'h8000);
    chk({fast_huff_o, marker_fast_o}, 2'h2);
  endtask : fast_modes
  task automatic op_modes;
    logic [2:0] m [4] = '{3'h0, 3'h3, 3'h7, 3'h5};
    logic [4:0] e [4] = '{5'h1C, 5'h01, 5'h02, 5'h18};
    for (int i = 0; i < 4; i++)
    begin
      wr({12'h0, m[i], 1'b1});
      chk({codec_clk_en_o, codec_access_o, encode_mode_o, capture_fmt_o}, e[i]);
    end
    wr(16'h0000);
    chk({module_clk_en_o, codec_clk_en_o, codec_access_o, encode_mode_o}, 4'h0);
  endtask : op_modes
  task automatic soft_reset;
    lb_overflow_i <= 1'b1;
    apb(1'b1, 12'h000, 32'h0080);
    lb_overflow_i <= 1'b0;
    @(posedge clk_i);
    chk({module_rst_o, lb_overflow_flag_o}, 2'h1);
    wr(16'h0001);
    apb(1'b1, 12'h000, 32'h8191);
    @(posedge clk_i);
    chk(module_rst_o, 1'b1);
    @(posedge clk_i);
    chk({module_rst_o, lb_overflow_flag_o}, 2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00008111);
  endtask : soft_reset
  task automatic uv_path;
    wr(16'h0001);
    chk(chroma_o, 8'h70);
    wr(16'h0011);
    chk(chroma_o, 8'hF0);
  endtask : uv_path
  task automatic bad_addr;
    apb(1'b1, 12'h004, 32'hFFFF);
    chk(er, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk({er, rd[15:0]}, 17'h10000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0011);
  endtask : bad_addr
  task automatic end_sim;
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    fast_modes();
    op_modes();
    soft_reset();
    uv_path();
    bad_addr();
    end_sim();
  end
  initial
  begin
    #40000;
    err_total++;
    end_sim();
  end
endmodule : tb_top
